// ### hdl/smpg_gen.sv
// Move profile generator: plans, checks and runs one move at a time
//
// What this block does
// R1 - Move checked and set up in one cycle before motion starts or error is reported; ramp and stop point are worked out while moving
// R2 - Rates come in steps/s per ms; per-second-squared equals value times 1000
// R3 - Multi-word format keeps position within -32768000 to +32767999
// R4 - 32-bit format keeps position within full signed 32-bit range
// R5 - Preset command loads position counter and makes home reference valid
// R6 - Home reached clears motor and encoder position to zero
// R7 - Positive moves count position up, negative moves count down
// R8 - Start speed accepted only 1 to 1999999; moves start and end there
// R9 - Relative target is signed offset, accepted within plus or minus 8388607
// R10 - Position may grow past 8388607 through repeated relative moves
// R11 - Absolute move refused while no valid home reference exists
// R12 - Absolute target within 8388607; direction from target versus position
// R13 - Absolute move never ends outside plus or minus 8388607
// R14 - Jerk zero gives constant rate change at programmed value
// R15 - Jerk 1 to 5000 gives S-curve; larger values rejected
// R16 - Jerk applied is parameter over 100 times acceleration
// R17 - S-curve ramps rate up, holds, then down to zero at top speed
// R18 - Short ramps give triangular rate shape without a flat segment
// R19 - Deceleration shaped the same way, ending at start speed on target
`timescale 1ns/10ps
module smpg_gen #(
  parameter int MS_CYCLES = smpg_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire smpg_pkg::smpg_cmd_type cmd,
  input wire logic fmt32,
  input wire logic [20:0] start_speed,
  input wire logic home_hit,
  output logic busy_q,
  output logic accept_q,
  output logic error_q,
  output smpg_pkg::smpg_err_type err_code_q,
  output logic signed [31:0] pos_q,
  output logic home_valid_q,
  output logic enc_clear_q,
  output logic step_q,
  output logic dir_q,
  output logic [20:0] speed_q
);
  typedef enum logic [2:0] {IDLE, PLAN, ACCEL, CRUISE, DECEL} smpg_state_type;

  // Per-ms rate step from jerk, in units of rate/100000 (R2, R16)
  function automatic logic [79:0] jerk_step(input logic [15:0] j, input logic [15:0] a);
    jerk_step = 80'(j) * 80'(a);
  endfunction : jerk_step

  // Next rate: rise by jerk, cap at max, fall once the speed gap is short
  function automatic logic [79:0] ramp(input logic [79:0] a, input logic [79:0] amax,
                                       input logic [79:0] js, input logic [79:0] gap);
    logic down;
    down = (gap * 80'd2 * js) <= (a * a);
    if (js == 80'd0)
      ramp = amax;
    else if (down)
      ramp = (a > js + js) ? a - js : js;
    else
      ramp = (a + js > amax) ? amax : a + js;
  endfunction : ramp

  // Wrap position into the selected format range
  function automatic logic signed [31:0] wrap_pos(input logic signed [31:0] p,
                                                  input logic f32);
    if (f32)
      wrap_pos = p;
    else if (p > smpg_pkg::MW_MAX)
      wrap_pos = smpg_pkg::MW_MIN;
    else if (p < smpg_pkg::MW_MIN)
      wrap_pos = smpg_pkg::MW_MAX;
    else
      wrap_pos = p;
  endfunction : wrap_pos

  smpg_state_type state_q, state_d;
  smpg_pkg::smpg_cmd_type mv_q, mv_d;
  logic [79:0] spd_s_q, spd_s_d, acc_q, acc_d;
  logic [25:0] ph_q, ph_d;
  logic [31:0] rem_q, rem_d;
  logic [31:0] tick_q, tick_d;
  logic busy_d, accept_d, error_d, home_valid_d, enc_clear_d, step_d, dir_d;
  smpg_pkg::smpg_err_type err_code_d;
  logic signed [31:0] pos_d;
  logic [20:0] speed_d;

  // Shared terms; fed from registers, except start_speed, which comes straight from its input
  logic signed [32:0] delta;
  logic [79:0] scale, vmax_s, vs_s, v_int, vs_int, dec_need, dec_have;
  logic tick;
  always_comb
  begin
    scale = 80'(smpg_pkg::JERK_SCALE);
    tick = (tick_q == 32'(MS_CYCLES - 1));
    delta = 33'(mv_q.target) - 33'(pos_q);
    vmax_s = 80'(mv_q.speed) * scale;
    vs_s = 80'(start_speed) * scale;
    v_int = spd_s_q / scale;
    vs_int = 80'(start_speed);
    // Distance needed to stop; doubled margin when the stop is S-shaped
    dec_have = 80'd2 * 80'(mv_q.decel) * 80'(smpg_pkg::ACC_PER_MS) * 80'(rem_q); // R2
    if (mv_q.dec_jerk != 16'h0000)
      dec_have = dec_have >> 1;
    dec_need = v_int * v_int - vs_int * vs_int;
  end

  // Profile state machine, position counter and step generator
  always_comb
  begin
    state_d = state_q;
    mv_d = mv_q;
    spd_s_d = spd_s_q;
    acc_d = acc_q;
    ph_d = ph_q;
    rem_d = rem_q;
    tick_d = (tick || state_q == IDLE) ? 32'h0 : tick_q + 32'h1;
    busy_d = busy_q;
    accept_d = 1'b0;
    error_d = 1'b0;
    err_code_d = err_code_q;
    pos_d = pos_q;
    home_valid_d = home_valid_q;
    enc_clear_d = 1'b0;
    step_d = 1'b0;
    dir_d = dir_q;
    speed_d = speed_q;
    unique case (state_q)
      IDLE:
      begin
        if (cmd_valid)
        begin
          mv_d = cmd;
          state_d = PLAN;
          busy_d = 1'b1;
        end
      end
      PLAN:
      begin
        // Every check done here, before any step leaves the block
        state_d = IDLE; // R1
        busy_d = 1'b0;
        error_d = 1'b1;
        if (mv_q.kind == smpg_pkg::SMPG_PRESET)
        begin
          pos_d = wrap_pos(mv_q.target, fmt32); // R5
          home_valid_d = 1'b1;
          error_d = 1'b0;
          accept_d = 1'b1;
          err_code_d = smpg_pkg::SMPG_OK;
        end
        else if (start_speed < smpg_pkg::START_MIN || start_speed > smpg_pkg::START_MAX)
          err_code_d = smpg_pkg::SMPG_BAD_START; // R8
        else if (mv_q.target > smpg_pkg::TGT_MAX || mv_q.target < smpg_pkg::TGT_MIN)
          err_code_d = smpg_pkg::SMPG_BAD_TARGET; // R9 R12 R13
        else if (mv_q.kind == smpg_pkg::SMPG_ABS && !home_valid_q)
          err_code_d = smpg_pkg::SMPG_NO_HOME; // R11
        else if (mv_q.acc_jerk > smpg_pkg::JERK_MAX || mv_q.dec_jerk > smpg_pkg::JERK_MAX)
          err_code_d = smpg_pkg::SMPG_BAD_JERK; // R15
        else if (mv_q.accel == 16'h0000 || mv_q.decel == 16'h0000 ||
                 mv_q.speed < start_speed)
          err_code_d = smpg_pkg::SMPG_BAD_RATE;
        else
        begin
          error_d = 1'b0;
          accept_d = 1'b1;
          err_code_d = smpg_pkg::SMPG_OK;
          if (mv_q.kind == smpg_pkg::SMPG_ABS)
          begin
            dir_d = (delta > 33'sd0); // R12
            rem_d = (delta < 33'sd0) ? 32'(-delta) : 32'(delta);
          end
          else
          begin
            dir_d = (mv_q.target > 32'sd0); // R7
            rem_d = (mv_q.target < 32'sd0) ? 32'(-mv_q.target) : 32'(mv_q.target);
          end
          // Moves open at start speed
          spd_s_d = vs_s; // R8
          speed_d = start_speed;
          acc_d = (mv_q.acc_jerk == 16'h0000) ? 80'(mv_q.accel) * scale : 80'h0; // R14
          ph_d = 26'h0;
          if (rem_d != 32'h0)
          begin
            state_d = ACCEL;
            busy_d = 1'b1;
          end
        end
      end
      ACCEL:
      begin
        if (dec_need >= dec_have)
        begin
          state_d = DECEL; // R19
          acc_d = (mv_q.dec_jerk == 16'h0000) ? 80'(mv_q.decel) * scale : 80'h0;
        end
        else if (tick)
        begin
          // Rate rises, holds, then falls to zero at top speed (triangle if short)
          acc_d = ramp(acc_q, 80'(mv_q.accel) * scale,
                       jerk_step(mv_q.acc_jerk, mv_q.accel),
                       vmax_s - spd_s_q); // R14 R15 R16 R17 R18
          if (spd_s_q + acc_d >= vmax_s)
          begin
            spd_s_d = vmax_s;
            state_d = CRUISE;
          end
          else
            spd_s_d = spd_s_q + acc_d;
        end
      end
      CRUISE:
      begin
        if (dec_need >= dec_have)
        begin
          state_d = DECEL;
          acc_d = (mv_q.dec_jerk == 16'h0000) ? 80'(mv_q.decel) * scale : 80'h0;
        end
      end
      DECEL:
      begin
        if (tick)
        begin
          // Same shaping as the rise, floored at start speed
          acc_d = ramp(acc_q, 80'(mv_q.decel) * scale,
                       jerk_step(mv_q.dec_jerk, mv_q.decel),
                       spd_s_q - vs_s); // R19
          spd_s_d = (spd_s_q < vs_s + acc_d) ? vs_s : spd_s_q - acc_d;
        end
      end
      default:
      begin
        state_d = IDLE;
      end
    endcase
    // Step clock: phase accumulator at the current whole speed
    if (state_q == ACCEL || state_q == CRUISE || state_q == DECEL)
    begin
      speed_d = 21'(v_int);
      if (ph_q + 26'(v_int) >= smpg_pkg::CLK_HZ)
      begin
        ph_d = ph_q + 26'(v_int) - smpg_pkg::CLK_HZ;
        step_d = 1'b1;
        rem_d = rem_q - 32'h1;
        // Count direction; wraps at the ends of the selected format range
        pos_d = wrap_pos(dir_q ? pos_q + smpg_pkg::POS_ONE : pos_q - smpg_pkg::POS_ONE,
                         fmt32); // R3 R4 R7 R10
        if (rem_q == 32'h1)
        begin
          state_d = IDLE;
          busy_d = 1'b0;
          // Coarse rate ticks can leave a residue; the move ends at start speed
          spd_s_d = vs_s; // R19
          speed_d = start_speed;
        end
      end
      else
        ph_d = ph_q + 26'(v_int);
    end
    // Home reached outranks any count in the same cycle
    if (home_hit)
    begin
      pos_d = 32'sh0; // R6
      enc_clear_d = 1'b1;
      home_valid_d = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= IDLE;
      mv_q <= '0;
      spd_s_q <= 80'h0;
      acc_q <= 80'h0;
      ph_q <= 26'h0;
      rem_q <= 32'h0;
      tick_q <= 32'h0;
      busy_q <= 1'b0;
      accept_q <= 1'b0;
      error_q <= 1'b0;
      err_code_q <= smpg_pkg::SMPG_OK;
      pos_q <= 32'sh0;
      home_valid_q <= 1'b0;
      enc_clear_q <= 1'b0;
      step_q <= 1'b0;
      dir_q <= 1'b0;
      speed_q <= 21'h0;
    end
    else
    begin
      state_q <= state_d;
      mv_q <= mv_d;
      spd_s_q <= spd_s_d;
      acc_q <= acc_d;
      ph_q <= ph_d;
      rem_q <= rem_d;
      tick_q <= tick_d;
      busy_q <= busy_d;
      accept_q <= accept_d;
      error_q <= error_d;
      err_code_q <= err_code_d;
      pos_q <= pos_d;
      home_valid_q <= home_valid_d;
      enc_clear_q <= enc_clear_d;
      step_q <= step_d;
      dir_q <= dir_d;
      speed_q <= speed_d;
    end
  end

  // Checks on the planner, counter and ramp
  a_answer_after_plan: assert property (@(posedge clk) disable iff (!rst_b) // R1
    (accept_q || error_q) |-> $past(state_q) == PLAN)
    else $error("answer without a planning cycle");
  a_abs_needs_home: assert property (@(posedge clk) disable iff (!rst_b) // R11
    (accept_q && mv_q.kind == smpg_pkg::SMPG_ABS) |-> $past(home_valid_q))
    else $error("absolute move taken without home");
  a_jerk_limit: assert property (@(posedge clk) disable iff (!rst_b) // R15
    (accept_q && mv_q.kind != smpg_pkg::SMPG_PRESET) |-> mv_q.acc_jerk <= smpg_pkg::JERK_MAX)
    else $error("jerk out of range accepted");
  a_mw_range: assert property (@(posedge clk) disable iff (!rst_b) // R3
    !fmt32 && $stable(fmt32) && $past(pos_q) <= smpg_pkg::MW_MAX
      && $past(pos_q) >= smpg_pkg::MW_MIN |-> pos_q <= smpg_pkg::MW_MAX
      && pos_q >= smpg_pkg::MW_MIN)
    else $error("position left multi-word range");
  a_step_count: assert property (@(posedge clk) disable iff (!rst_b) // R7
    step_q && !$past(home_hit) && !(pos_q == smpg_pkg::MW_MIN || pos_q == smpg_pkg::MW_MAX)
      |-> pos_q == (dir_q ? $past(pos_q) + 32'sh1 : $past(pos_q) - 32'sh1))
    else $error("step did not move position by one");
  a_home_clear: assert property (@(posedge clk) disable iff (!rst_b) // R6
    home_hit |=> pos_q == 32'sh0 && enc_clear_q && home_valid_q)
    else $error("home reached without clearing");
  a_preset_load: assert property (@(posedge clk) disable iff (!rst_b) // R5
    state_q == PLAN && mv_q.kind == smpg_pkg::SMPG_PRESET && !home_hit
      |=> accept_q && home_valid_q)
    else $error("preset not taken");
  a_speed_floor: assert property (@(posedge clk) disable iff (!rst_b) // R8
    busy_q && state_q == DECEL |-> spd_s_q >= vs_s)
    else $error("speed below start speed");
  a_start_check: assert property (@(posedge clk) disable iff (!rst_b) // R8
    (accept_q && mv_q.kind != smpg_pkg::SMPG_PRESET) |-> start_speed >= smpg_pkg::START_MIN)
    else $error("zero start speed accepted");
endmodule : smpg_gen

// ### common/smpg_pkg.sv
// Shared types and constants for the stepper move profile generator
package smpg_pkg;
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [25:0] CLK_HZ = 26'(CLK_MHZ * 1000000);
  localparam logic [9:0] ACC_PER_MS = 10'd1000;
  localparam logic [16:0] JERK_SCALE = 17'd100000;
  localparam logic [15:0] JERK_MAX = 16'd5000;
  localparam logic [20:0] START_MIN = 21'd1;
  localparam logic [20:0] START_MAX = 21'd1999999;
  localparam logic signed [31:0] TGT_MAX = 32'sh007FFFFF;
  localparam logic signed [31:0] TGT_MIN = -32'sh007FFFFF;
  localparam logic signed [31:0] MW_MAX = 32'sh01F3FFFF;
  localparam logic signed [31:0] MW_MIN = -32'sh01F40000;
  localparam logic signed [31:0] POS_ONE = 32'sh00000001;

  typedef enum logic [1:0] {
    SMPG_REL,
    SMPG_ABS,
    SMPG_PRESET
  } smpg_kind_type;

  typedef enum logic [2:0] {
    SMPG_OK,
    SMPG_BAD_TARGET,
    SMPG_NO_HOME,
    SMPG_BAD_JERK,
    SMPG_BAD_START,
    SMPG_BAD_RATE,
    SMPG_BUSY
  } smpg_err_type;

  typedef struct packed {
    smpg_kind_type kind;
    logic signed [31:0] target;
    logic [20:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] acc_jerk;
    logic [15:0] dec_jerk;
  } smpg_cmd_type;
endpackage : smpg_pkg

// ### testbench/smpg_host.sv
// Host-side model that issues move commands to the profile generator
`timescale 1ns/10ps
module smpg_host (
  input wire logic clk,
  output logic cmd_valid,
  output smpg_pkg::smpg_cmd_type cmd
);
  // Quiet bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One-cycle strobe; stale data inverted so it never looks valid
  task automatic send(input smpg_pkg::smpg_cmd_type c);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd = smpg_pkg::smpg_cmd_type'(~c);
  endtask : send
endmodule : smpg_host

// ### testbench/smpg_gen_tb.sv
// Self-checking bench for the move profile generator
`timescale 1ns/10ps
module smpg_gen_tb;
  typedef struct {
    logic err;
    smpg_pkg::smpg_err_type code;
    logic mv;
    logic dir;
    logic signed [31:0] pos;
    int steps;
  } smpg_note_type;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic fmt32 = 1'b0;
  logic [20:0] start_speed = 21'h7A120;
  logic home_hit = 1'b0;
  logic cmd_valid;
  smpg_pkg::smpg_cmd_type cmd;
  logic busy_q, accept_q, error_q, home_valid_q, enc_clear_q, step_q, dir_q;
  smpg_pkg::smpg_err_type err_code_q;
  logic signed [31:0] pos_q;
  logic [20:0] speed_q;
  smpg_note_type exp_q[$];
  int failures = 0;
  int tests_run = 0;
  int done_cnt = 0;
  logic signed [31:0] pos_m = '0;
  logic signed [31:0] t;

  // 50 MHz clock
  always #10 clk = ~clk;

  // Short rate tick keeps runs small
  smpg_gen #(.MS_CYCLES(50)) smpg_gen_i (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd(cmd), .fmt32(fmt32), .start_speed(start_speed), .home_hit(home_hit),
    .busy_q(busy_q), .accept_q(accept_q), .error_q(error_q), .err_code_q(err_code_q),
    .pos_q(pos_q), .home_valid_q(home_valid_q), .enc_clear_q(enc_clear_q),
    .step_q(step_q), .dir_q(dir_q), .speed_q(speed_q));
  smpg_host smpg_host_i (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));

  task automatic summarize();
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Model of the position counter; multi-word format wraps at its ends
  function automatic logic signed [31:0] wrap(input logic signed [31:0] p);
    if (fmt32 === 1'b0 && p > smpg_pkg::MW_MAX)
      return p - smpg_pkg::MW_MAX + smpg_pkg::MW_MIN - 32'sh1;
    if (fmt32 === 1'b0 && p < smpg_pkg::MW_MIN)
      return p - smpg_pkg::MW_MIN + smpg_pkg::MW_MAX + 32'sh1;
    return p;
  endfunction : wrap

  // Waits for the move to end and counts the step pulses seen on the way
  task automatic wait_idle(output int s);
    int n;
    n = 0;
    s = 0;
    while (busy_q !== 1'b0)
    begin
      @(negedge clk);
      n++;
      if (step_q === 1'b1)
        s++;
      if (n > 40000)
      begin
        failures++;
        summarize();
      end
    end
    @(negedge clk);
  endtask : wait_idle

  // Send one command and note what the answer and final position must be
  task automatic go(input smpg_pkg::smpg_kind_type k, input logic signed [31:0] tg,
    input logic [15:0] aj, input logic [15:0] dj, input smpg_pkg::smpg_err_type c);
    smpg_note_type e;
    int d;
    int n;
    e.err = (c != smpg_pkg::SMPG_OK);
    e.code = c;
    e.mv = !e.err && k != smpg_pkg::SMPG_PRESET;
    e.dir = (k == smpg_pkg::SMPG_ABS) ? (tg > pos_m) : (tg > 0);
    e.steps = 0;
    if (!e.err && k != smpg_pkg::SMPG_PRESET)
      e.steps = (k == smpg_pkg::SMPG_ABS) ? int'(tg - pos_m) : int'(tg);
    if (e.steps < 0)
      e.steps = -e.steps;
    if (!e.err)
      pos_m = (k == smpg_pkg::SMPG_REL) ? wrap(pos_m + tg) : tg;
    e.pos = pos_m;
    exp_q.push_back(e);
    d = done_cnt;
    smpg_host_i.send('{k, tg, 21'hF4240, 16'h3E8, 16'h3E8, aj, dj});
    n = 0;
    while (done_cnt == d)
    begin
      @(negedge clk);
      n++;
      if (n > 50000)
      begin
        failures++;
        summarize();
      end
    end
  endtask : go

  // Watcher: takes the oldest note on each answer pulse
  initial
  begin : watch
    smpg_note_type e;
    int s;
    forever
    begin
      @(negedge clk);
      if (enc_clear_q === 1'b1)
      begin
        chk(pos_q, 32'h0, "home position");
        chk({31'h0, home_valid_q}, 32'h1, "home valid");
      end
      if (accept_q === 1'b1 || error_q === 1'b1)
      begin
        e = exp_q.pop_front();
        chk({31'h0, error_q}, {31'h0, e.err}, "answer");
        chk({29'h0, err_code_q}, {29'h0, e.code}, "code");
        if (e.mv)
        begin
          chk({31'h0, dir_q}, {31'h0, e.dir}, "direction");
          chk({11'h0, speed_q}, {11'h0, start_speed}, "first speed");
        end
        wait_idle(s);
        chk(s, e.steps, "step count");
        chk(pos_q, e.pos, "position");
        if (e.mv)
          chk({11'h0, speed_q}, {11'h0, start_speed}, "last speed");
        done_cnt++;
      end
    end
  end

  // Main sequence: refusals first, then moves, wraps and homing
  initial
  begin
    void'($urandom(32'h42C54F2F));
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    start_speed = 21'h0;
    go(smpg_pkg::SMPG_REL, 32'shA, 16'h0, 16'h0, smpg_pkg::SMPG_BAD_START);
    start_speed = 21'h1E8480;
    go(smpg_pkg::SMPG_REL, 32'shA, 16'h0, 16'h0, smpg_pkg::SMPG_BAD_START);
    start_speed = 21'h186A00;
    go(smpg_pkg::SMPG_REL, 32'shA, 16'h0, 16'h0, smpg_pkg::SMPG_BAD_RATE);
    start_speed = 21'h7A120;
    go(smpg_pkg::SMPG_ABS, 32'sh5, 16'h0, 16'h0, smpg_pkg::SMPG_NO_HOME);
    go(smpg_pkg::SMPG_REL, 32'sh800000, 16'h0, 16'h0, smpg_pkg::SMPG_BAD_TARGET);
    go(smpg_pkg::SMPG_REL, -32'sh800000, 16'h0, 16'h0, smpg_pkg::SMPG_BAD_TARGET);
    go(smpg_pkg::SMPG_REL, 32'shA, 16'h1389, 16'h0, smpg_pkg::SMPG_BAD_JERK);
    go(smpg_pkg::SMPG_REL, 32'shA, 16'h0, 16'h1389, smpg_pkg::SMPG_BAD_JERK);
    go(smpg_pkg::SMPG_REL, 32'sh14, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    go(smpg_pkg::SMPG_REL, -32'sh7, 16'h1388, 16'h1, smpg_pkg::SMPG_OK);
    go(smpg_pkg::SMPG_PRESET, 32'sh64, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    repeat (3)
    begin
      t = 32'sh5A + 32'($urandom_range(20));
      if (t == pos_m)
        t = t + 32'sh1;
      go(smpg_pkg::SMPG_ABS, t, 16'h64, 16'h0, smpg_pkg::SMPG_OK);
    end
    go(smpg_pkg::SMPG_ABS, 32'sh800000, 16'h0, 16'h0, smpg_pkg::SMPG_BAD_TARGET);
    go(smpg_pkg::SMPG_PRESET, smpg_pkg::MW_MAX, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    go(smpg_pkg::SMPG_REL, 32'sh1, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    fmt32 = 1'b1;
    go(smpg_pkg::SMPG_PRESET, 32'sh7FFFFFFF, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    go(smpg_pkg::SMPG_REL, 32'sh1, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    fmt32 = 1'b0;
    go(smpg_pkg::SMPG_PRESET, smpg_pkg::TGT_MAX, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    go(smpg_pkg::SMPG_REL, 32'sh3, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    go(smpg_pkg::SMPG_ABS, 32'sh7FFFF8, 16'h0, 16'h0, smpg_pkg::SMPG_OK);
    home_hit = 1'b1;
    @(negedge clk);
    home_hit = 1'b0;
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule : smpg_gen_tb
